// *** design/dram_ctrl_defines.svh ***
// Timing and geometry constants for the page-mode dynamic memory controller.
`ifndef DRAM_CTRL_DEFINES_SVH
`define DRAM_CTRL_DEFINES_SVH
`define CLK_PERIOD_NS        40
`define ADDR_W               18
`define HALF_W               9
`define DATA_W               16
`define ROW_ACTIVE_MIN_NS    60
`define ROW_PRECHARGE_NS     40
`define COL_PRECHARGE_NS     10
`define ACCESS_NS            60
`define POWER_UP_WAIT_US     200
`define WAKE_CYCLES          8
`define REFRESH_ROWS         512
`define REFRESH_PERIOD_MS    8
`define RAS_CYC  (((`ROW_ACTIVE_MIN_NS) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RP_CYC   (((`ROW_PRECHARGE_NS) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CP_CYC   (((`COL_PRECHARGE_NS) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ACC_CYC  (((`ACCESS_NS) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PWR_CYC  (((`POWER_UP_WAIT_US) * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define REF_INTERVAL_CYC (((`REFRESH_PERIOD_MS) * 1000000 / `CLK_PERIOD_NS) / `REFRESH_ROWS)
`endif

// *** design/dram_ctrl_pkg.sv ***
// Types shared by the page-mode dynamic memory controller.
package dram_ctrl_pkg;
  typedef enum logic [3:0] {
    ST_POWER_WAIT = 4'h0,
    ST_IDLE       = 4'h1,
    ST_ROW_OPEN   = 4'h2,
    ST_COL_LOW    = 4'h3,
    ST_COL_HIGH   = 4'h4,
    ST_ROW_CLOSE  = 4'h5,
    ST_PRECHARGE  = 4'h6,
    ST_REF_COL    = 4'h7,
    ST_REF_ROW    = 4'h8
  } state_t;
endpackage

// *** design/edo_page_dram_interface.sv ***
// Controller that drives a strobe-multiplexed page-mode dynamic memory.
`timescale 1ns/1ps
`include "dram_ctrl_defines.svh"

module edo_page_dram_interface (
  input  wire logic                clock,
  input  wire logic                srst,
  input  wire logic                req_valid,
  output logic                     req_ready,
  input  wire logic                req_write,
  input  wire logic [17:0]         req_addr,
  input  wire logic [1:0]          req_byte_en,
  input  wire logic [15:0]         req_wdata,
  output logic                     rsp_valid,
  output logic [15:0]              rsp_rdata,
  output logic                     init_done,
  output logic                     row_strobe_n,
  output logic                     low_byte_col_strobe_n,
  output logic                     high_byte_col_strobe_n,
  output logic                     write_enable_n,
  output logic                     output_enable_n,
  output logic [8:0]               mux_address_pins,
  input  wire logic [15:0]         data_lines_in,
  output logic [15:0]              data_lines_out,
  output logic [15:0]              data_lines_oe
);

  localparam logic [15:0] RAS_CYC  = 16'(`RAS_CYC);
  localparam logic [15:0] RP_CYC   = 16'(`RP_CYC);
  localparam logic [15:0] CP_CYC   = 16'(`CP_CYC);
  localparam logic [15:0] ACC_CYC  = 16'(`ACC_CYC);
  localparam logic [15:0] PWR_CYC  = 16'(`PWR_CYC);
  localparam logic [15:0] REF_CYC  = 16'(`REF_INTERVAL_CYC);
  localparam logic [3:0]  WAKE_CYC = 4'(`WAKE_CYCLES);

  dram_ctrl_pkg::state_t state_r;
  logic [15:0] timer_r;
  logic [15:0] ref_timer_r;
  logic        ref_pending_r;
  logic        ref_overdue_r;
  logic [3:0]  wake_cnt_r;
  logic        op_write_r;
  logic [8:0]  row_r;
  logic [8:0]  col_r;
  logic [1:0]  be_r;
  logic [15:0] wdata_r;
  logic        page_hit;
  logic        timer_done;

  assign timer_done = (timer_r == 16'h0000);
  // A new request may reuse the open row only when no refresh is waiting.
  assign page_hit  = req_valid && (req_addr[17:9] == row_r) && !ref_pending_r;
  assign req_ready = (state_r == dram_ctrl_pkg::ST_IDLE || state_r == dram_ctrl_pkg::ST_COL_HIGH)
                     && timer_done && !ref_pending_r && init_done
                     && (state_r == dram_ctrl_pkg::ST_IDLE || page_hit);

  // Refresh interval timer; one request per 391-cycle row slot covers 512 rows in just over 8 ms.
  // A slot that expires with one still pending marks the period overdue.
  always_ff @(posedge clock) begin
    if (srst) begin
      ref_timer_r   <= REF_CYC;
      ref_pending_r <= 1'b0;
      ref_overdue_r <= 1'b0;
    end else begin
      if (ref_timer_r == 16'h0000) begin
        ref_timer_r <= REF_CYC;
      end else begin
        ref_timer_r <= ref_timer_r - 16'h0001;
      end
      // Set beats clear so no slot is lost.
      if (ref_timer_r == 16'h0000 && init_done) begin
        ref_pending_r <= 1'b1;
        if (ref_pending_r) begin
          ref_overdue_r <= 1'b1;
        end
      end else if (state_r == dram_ctrl_pkg::ST_REF_COL) begin
        ref_pending_r <= 1'b0;
        ref_overdue_r <= 1'b0;
      end
    end
  end

  // Main strobe sequencer; strobe edges are spaced by the derived cycle counts, except the one-cycle row-open and row-close steps.
  always_ff @(posedge clock) begin
    if (srst) begin
      state_r    <= dram_ctrl_pkg::ST_POWER_WAIT;
      timer_r    <= PWR_CYC;
      wake_cnt_r <= 4'h0;
      init_done  <= 1'b0;
      op_write_r <= 1'b0;
      row_r      <= 9'h000;
      col_r      <= 9'h000;
      be_r       <= 2'b00;
      wdata_r    <= 16'h0000;
    end else begin
      if (!timer_done) begin
        timer_r <= timer_r - 16'h0001;
      end
      case (state_r)
        dram_ctrl_pkg::ST_POWER_WAIT: begin
          // Strobes sit high through power-up to avoid surge current.
          if (timer_done) begin
            state_r <= dram_ctrl_pkg::ST_REF_COL;
            timer_r <= CP_CYC;
          end
        end
        dram_ctrl_pkg::ST_IDLE: begin
          if (ref_overdue_r) begin
            init_done  <= 1'b0;
            wake_cnt_r <= 4'h0;
            state_r    <= dram_ctrl_pkg::ST_REF_COL;
            timer_r    <= CP_CYC;
          end else if ((ref_pending_r || !init_done) && timer_done) begin
            // Until eight wake-up pulses are counted, idle only ever launches the next one.
            state_r <= dram_ctrl_pkg::ST_REF_COL;
            timer_r <= CP_CYC;
          end else if (req_ready && req_valid) begin
            op_write_r <= req_write;
            row_r      <= req_addr[17:9];
            col_r      <= req_addr[8:0];
            be_r       <= req_byte_en;
            wdata_r    <= req_wdata;
            state_r    <= dram_ctrl_pkg::ST_ROW_OPEN;
            timer_r    <= RAS_CYC;
          end
        end
        dram_ctrl_pkg::ST_ROW_OPEN: begin
          state_r <= dram_ctrl_pkg::ST_COL_LOW;
          timer_r <= ACC_CYC;
        end
        dram_ctrl_pkg::ST_COL_LOW: begin
          // Column strobe stays low until the slowest access time has passed.
          if (timer_done) begin
            state_r <= dram_ctrl_pkg::ST_COL_HIGH;
            timer_r <= CP_CYC;
          end
        end
        dram_ctrl_pkg::ST_COL_HIGH: begin
          if (req_ready && req_valid) begin
            op_write_r <= req_write;
            col_r      <= req_addr[8:0];
            be_r       <= req_byte_en;
            wdata_r    <= req_wdata;
            state_r    <= dram_ctrl_pkg::ST_COL_LOW;
            timer_r    <= ACC_CYC;
          end else if (timer_done) begin
            state_r <= dram_ctrl_pkg::ST_ROW_CLOSE;
          end
        end
        dram_ctrl_pkg::ST_ROW_CLOSE: begin
          state_r <= dram_ctrl_pkg::ST_PRECHARGE;
          timer_r <= RP_CYC;
        end
        dram_ctrl_pkg::ST_PRECHARGE: begin
          if (timer_done) begin
            state_r <= dram_ctrl_pkg::ST_IDLE;
          end
        end
        dram_ctrl_pkg::ST_REF_COL: begin
          // Both column strobes drop before the row strobe.
          if (timer_done) begin
            state_r <= dram_ctrl_pkg::ST_REF_ROW;
            timer_r <= RAS_CYC;
          end
        end
        dram_ctrl_pkg::ST_REF_ROW: begin
          if (timer_done) begin
            state_r <= dram_ctrl_pkg::ST_PRECHARGE;
            timer_r <= RP_CYC;
            if (!init_done) begin
              if (wake_cnt_r == WAKE_CYC - 4'h1) begin
                init_done <= 1'b1;
              end else begin
                wake_cnt_r <= wake_cnt_r + 4'h1;
              end
            end
          end
        end
        default: begin
          state_r <= dram_ctrl_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Strobe pins decoded from the registered state; address pins also take the row of a request accepted in idle.
  always_ff @(posedge clock) begin
    if (srst) begin
      row_strobe_n           <= 1'b1;
      low_byte_col_strobe_n  <= 1'b1;
      high_byte_col_strobe_n <= 1'b1;
      write_enable_n         <= 1'b1;
      output_enable_n        <= 1'b1;
      mux_address_pins       <= 9'h000;
      data_lines_out         <= 16'h0000;
      data_lines_oe          <= 16'h0000;
    end else begin
      row_strobe_n           <= !(state_r == dram_ctrl_pkg::ST_ROW_OPEN || state_r == dram_ctrl_pkg::ST_COL_LOW
                                  || state_r == dram_ctrl_pkg::ST_COL_HIGH
                                  || state_r == dram_ctrl_pkg::ST_REF_ROW);
      low_byte_col_strobe_n  <= !((state_r == dram_ctrl_pkg::ST_COL_LOW && be_r[0])
                                  || state_r == dram_ctrl_pkg::ST_REF_COL
                                  || state_r == dram_ctrl_pkg::ST_REF_ROW);
      high_byte_col_strobe_n <= !((state_r == dram_ctrl_pkg::ST_COL_LOW && be_r[1])
                                  || state_r == dram_ctrl_pkg::ST_REF_COL
                                  || state_r == dram_ctrl_pkg::ST_REF_ROW);
      // Early write: write enable falls with the column strobe, output enable stays high.
      write_enable_n         <= !(state_r == dram_ctrl_pkg::ST_COL_LOW && op_write_r);
      output_enable_n        <= !(state_r == dram_ctrl_pkg::ST_COL_LOW && !op_write_r);
      // The row leaves one edge ahead of its strobe, so it has settled when the strobe falls.
      mux_address_pins       <= (state_r == dram_ctrl_pkg::ST_COL_LOW) ? col_r
                                : (state_r == dram_ctrl_pkg::ST_IDLE && req_ready && req_valid) ? req_addr[17:9]
                                : row_r;
      data_lines_out         <= wdata_r;
      // Drive only strobed lanes during writes; never during refresh.
      data_lines_oe          <= (state_r == dram_ctrl_pkg::ST_COL_LOW && op_write_r)
                                ? {{8{be_r[1]}}, {8{be_r[0]}}} : 16'h0000;
    end
  end

  // Read data sampled on the last cycle of the column-low phase.
  always_ff @(posedge clock) begin
    if (srst) begin
      rsp_valid <= 1'b0;
      rsp_rdata <= 16'h0000;
    end else begin
      rsp_valid <= 1'b0;
      if (state_r == dram_ctrl_pkg::ST_COL_LOW && timer_done && !op_write_r) begin
        rsp_valid <= 1'b1;
        rsp_rdata <= data_lines_in;
      end
    end
  end

endmodule // edo_page_dram_interface

// *** dv/edo_page_dram_interface_checker.sv ***
// Checker of the strobe timing that the memory controller drives.
`timescale 1ns/1ps
`include "dram_ctrl_defines.svh"
module edo_page_dram_interface_checker (
  input wire logic        clock,
  input wire logic        srst,
  input wire logic        req_valid,
  input wire logic        req_ready,
  input wire logic [17:0] req_addr,
  input wire logic        rsp_valid,
  input wire logic        init_done,
  input wire logic        row_strobe_n,
  input wire logic        low_byte_col_strobe_n,
  input wire logic        high_byte_col_strobe_n,
  input wire logic        write_enable_n,
  input wire logic        output_enable_n,
  input wire logic [8:0]  mux_address_pins,
  input wire logic [15:0] data_lines_oe
);
  localparam int PWR = `PWR_CYC;
  localparam int GAP = 2 * `REF_INTERVAL_CYC;
  logic [15:0] cyc_r;
  logic [15:0] gap_r;
  logic [3:0]  ras_r;
  logic [17:0] addr_r;
  wire         col_n = low_byte_col_strobe_n & high_byte_col_strobe_n;
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  // Time since reset, row pulses seen, time since the last refresh, and the address last taken.
  always_ff @(posedge clock) begin
    cyc_r <= srst ? 16'h0 : cyc_r + {15'h0, cyc_r != 16'hffff};
    ras_r <= srst ? 4'h0 : ras_r + {3'h0, $fell(row_strobe_n) && ras_r != 4'hf};
    gap_r <= (!init_done || ($fell(row_strobe_n) && !col_n)) ? 16'h0 : gap_r + 16'h1;
    if (req_valid && req_ready) addr_r <= req_addr;
  end
  property p_wait; $fell(row_strobe_n) |-> cyc_r >= PWR; endproperty
  a_wait: assert property (p_wait) else $error("row strobe too early");
  property p_wake; $rose(init_done) |-> ras_r >= 4'h8; endproperty
  a_wake: assert property (p_wake) else $error("too few wake cycles");
  property p_ras; $fell(row_strobe_n) |=> !row_strobe_n; endproperty
  a_ras: assert property (p_ras) else $error("row pulse too short");
  property p_read; !output_enable_n |-> write_enable_n && data_lines_oe == 16'h0; endproperty
  a_read: assert property (p_read) else $error("read with write or drive");
  property p_wdat; !write_enable_n && !col_n |-> (low_byte_col_strobe_n || &data_lines_oe[7:0])
    && (high_byte_col_strobe_n || &data_lines_oe[15:8]); endproperty
  a_wdat: assert property (p_wdat) else $error("write data late");
  property p_cbr; $fell(row_strobe_n) && !col_n |-> data_lines_oe == 16'h0 ##1 data_lines_oe == 16'h0; endproperty
  a_cbr: assert property (p_cbr) else $error("drive in refresh");
  property p_row; $fell(row_strobe_n) && col_n |-> mux_address_pins == addr_r[17:9]; endproperty
  a_row: assert property (p_row) else $error("bad row address");
  property p_col; $fell(col_n) && !row_strobe_n |-> mux_address_pins == addr_r[8:0]; endproperty
  a_col: assert property (p_col) else $error("bad column address");
  property p_gap; init_done |-> gap_r <= GAP; endproperty
  a_gap: assert property (p_gap) else $error("refresh overdue");
  c_cbr: cover property ($fell(row_strobe_n) && !col_n);
  c_read: cover property (rsp_valid);
  c_write: cover property (!write_enable_n && !col_n);
endmodule // edo_page_dram_interface_checker
bind edo_page_dram_interface edo_page_dram_interface_checker edo_page_dram_interface_checker_i (.clock, .srst,
  .req_valid, .req_ready, .req_addr, .rsp_valid, .init_done, .row_strobe_n, .low_byte_col_strobe_n,
  .high_byte_col_strobe_n, .write_enable_n, .output_enable_n, .mux_address_pins, .data_lines_oe);

// *** dv/dram_model.sv ***
// Behavioural model of the strobe-driven page-mode memory.
`timescale 1ns/1ps
module dram_model (
  input  wire logic        row_strobe_n,
  input  wire logic        low_byte_col_strobe_n,
  input  wire logic        high_byte_col_strobe_n,
  input  wire logic        write_enable_n,
  input  wire logic        output_enable_n,
  input  wire logic [8:0]  mux_address_pins,
  input  wire logic [15:0] bus,
  output logic      [15:0] q
);
  logic [15:0] mem [0:262143];
  logic [15:0] q_r = 16'h0;
  logic [8:0]  row_r = 9'h0;
  logic [17:0] a_r = 18'h0;
  logic [1:0]  drv = 2'h0;
  logic        cbr_r = 1'b0;
  // A row fall with a byte strobe low is taken as a refresh and ignores the pins.
  always @(negedge row_strobe_n) begin
    cbr_r = !(low_byte_col_strobe_n && high_byte_col_strobe_n);
    if (!cbr_r) row_r = mux_address_pins;
  end
  // The delay lets the controller's same-edge updates land before the bus is sampled.
  always @(negedge low_byte_col_strobe_n or negedge high_byte_col_strobe_n or negedge write_enable_n) begin
    #1;
    if (!row_strobe_n && !cbr_r) begin
      a_r = {row_r, mux_address_pins};
      if (!write_enable_n) begin
        if (!low_byte_col_strobe_n) mem[a_r][7:0] = bus[7:0];
        if (!high_byte_col_strobe_n) mem[a_r][15:8] = bus[15:8];
      end else q_r = mem[a_r];
    end
  end
  // Read lanes keep driving past the strobe rise until standby, a write or a high output enable.
  always @* begin
    for (int b = 0; b < 2; b++)
      if ((row_strobe_n && low_byte_col_strobe_n && high_byte_col_strobe_n) || output_enable_n
          || !write_enable_n || cbr_r) drv[b] = 1'b0;
      else if (!(b ? high_byte_col_strobe_n : low_byte_col_strobe_n)) drv[b] = 1'b1;
  end
  // Undriven lanes show the inverse of the last data so a stale read cannot pass.
  assign q = q_r ^ ~{{8{drv[1]}}, {8{drv[0]}}};
endmodule // dram_model

// *** dv/edo_page_dram_interface_tb.sv ***
// Self-checking bench of the controller against the memory model.
`timescale 1ns/1ps
module edo_page_dram_interface_tb;
  typedef struct packed {logic w; logic h; logic [17:0] a; logic [1:0] be; logic [15:0] d;} req_t;
  logic        clock = 1'b0, srst = 1'b1, req_valid = 1'b0, req_write = 1'b0;
  logic [17:0] req_addr = 18'h0;
  logic [1:0]  req_byte_en = 2'h0;
  logic [15:0] req_wdata = 16'h0, rsp_rdata, data_lines_out, data_lines_oe, q, bus;
  logic [8:0]  mux_address_pins;
  logic        req_ready, rsp_valid, init_done, row_strobe_n, low_byte_col_strobe_n, high_byte_col_strobe_n;
  logic        write_enable_n, output_enable_n;
  int          fail_count = 0, compares = 0;
  // Writes with held valid, page hits, byte lanes, a write with both byte enables clear, then reads back.
  req_t        tbl [16] = '{
    '{1, 1, 18'h00000, 3, 16'h1234}, '{1, 0, 18'h00001, 3, 16'ha5c3}, '{1, 0, 18'h3fe07, 3, 16'h0f0f},
    '{1, 0, 18'h3ffff, 3, 16'hbeef}, '{0, 0, 18'h00001, 3, 16'ha5c3}, '{0, 0, 18'h00000, 3, 16'h1234},
    '{0, 0, 18'h3fe07, 3, 16'h0f0f}, '{1, 0, 18'h00000, 1, 16'hffee}, '{1, 0, 18'h00001, 2, 16'h77aa},
    '{1, 0, 18'h00000, 0, 16'h0000}, '{0, 0, 18'h00000, 3, 16'h12ee}, '{0, 0, 18'h00001, 3, 16'h77c3},
    '{0, 0, 18'h3fe07, 1, 16'h0f0f}, '{0, 0, 18'h3fe07, 2, 16'h0f0f}, '{0, 0, 18'h3ffff, 3, 16'hbeef},
    '{0, 0, 18'h00000, 3, 16'h12ee}};
  assign bus = (data_lines_out & data_lines_oe) | (q & ~data_lines_oe);
  always #20 clock = ~clock;
  edo_page_dram_interface edo_page_dram_interface_i (.clock, .srst, .req_valid, .req_ready, .req_write, .req_addr,
    .req_byte_en, .req_wdata, .rsp_valid, .rsp_rdata, .init_done, .row_strobe_n, .low_byte_col_strobe_n,
    .high_byte_col_strobe_n, .write_enable_n, .output_enable_n, .mux_address_pins, .data_lines_in(bus),
    .data_lines_out, .data_lines_oe);
  dram_model dram_model_i (.row_strobe_n, .low_byte_col_strobe_n, .high_byte_col_strobe_n, .write_enable_n,
    .output_enable_n, .mux_address_pins, .bus, .q);
  task automatic give_verdict();
    if (fail_count == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic bail();
    fail_count++;
    $display("[FAIL] %0t wait limit reached", $time);
    give_verdict();
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask
  task automatic wait_init();
    int n;
    n = 0;
    do @(posedge clock); while (init_done !== 1'b1 && n++ < 6000);
    if (n > 6000) bail();
  endtask
  // A held request keeps valid up so the next one follows at once; a read waits for its answer.
  task automatic xfer(input req_t r);
    int n;
    n = 0;
    req_valid <= 1'b1;
    req_write <= r.w;
    req_addr <= r.a;
    req_byte_en <= r.be;
    req_wdata <= r.d;
    do @(posedge clock); while (req_ready !== 1'b1 && n++ < 2000);
    if (n > 2000) bail();
    if (!r.h) req_valid <= 1'b0;
    if (r.w) begin
      if (!r.h) @(posedge clock);
    end else begin
      n = 0;
      do @(posedge clock); while (rsp_valid !== 1'b1 && n++ < 50);
      if (n > 50) bail();
      chk(rsp_rdata & {{8{r.be[1]}}, {8{r.be[0]}}}, r.d & {{8{r.be[1]}}, {8{r.be[0]}}}, "read data");
    end
  endtask
  initial begin
    repeat (20) @(posedge clock);
    srst <= 1'b0;
    wait_init();
    for (int i = 0; i < 14; i++) xfer(tbl[i]);
    repeat (1000) @(posedge clock);
    xfer(tbl[14]);
    srst <= 1'b1;
    repeat (2) @(posedge clock);
    chk({row_strobe_n, init_done, 14'h0}, 16'h8000, "reset strobes");
    chk(data_lines_oe, 16'h0, "reset drive");
    srst <= 1'b0;
    wait_init();
    xfer(tbl[15]);
    give_verdict();
  end
endmodule // edo_page_dram_interface_tb
